/* cwd_config_decoder.sv */
// configuration word store, field decoder and power-up sequencer
//
// Contract
// [R01] a programmed bit reads 0, an unprogrammed bit reads 1
// [R02] word lives at 2007h, reachable only while programming mode is active
// [R03] erased word is 3FFFh, every setting at its default
// [R04] bit 13 low protects all program memory
// [R05] bit 12 routes capture/compare to portb pin 2 (1) or pin 3 (0)
// [R06] bit 11 low gives portb pins 6 and 7 to the debugger
// [R07] small variant write guard: 11 off, 10 to 01FF, 01 to 03FF
// [R08] large variant write guard: 11 off, 10/01/00 up to 01FF/03FF/05FF
// [R09] bit 8 low protects data eeprom
// [R10] bit 7 high gives portb pin 3 the low-voltage programming function
// [R11] bit 6 enables brown-out reset
// [R12] bit 5 low makes porta pin 5 I/O and ties master clear inactive
// [R13] bit 3 low enables the power-up delay timer
// [R14] bit 2 enables the watchdog
// [R15] oscillator codes 111 to 100: rc modes and pin 6/7 functions
// [R16] oscillator codes 011 to 000: external clock and three crystal modes
// [R17] power-up delay of 72 ms, only after power-on or brown-out
// [R18] start-up timer holds reset until the crystal is stable
// [R19] sleep ends on external reset, watchdog wake-up or interrupt
// [R20] unimplemented bits of the word read back as 1
// [R21] start-up timer counts 1024 oscillator cycles, crystal modes, power-on or wake
// [R22] fields latched during reset and held static while running
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
module cwd_config_decoder
  import cwd_pkg::*;
#(
  parameter bit LARGE_MEM  = 1'b1,
  parameter int POWERUP_DELAY_TIMER_LIMIT = POWERUP_DELAY_TIMER_CYCLES
) (
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  // register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic              wr_en_i,
  input  wire logic              rd_en_i,
  output logic      [DATA_W-1:0] rd_data_o,
  // asynchronous pins
  input  wire logic              prog_mode_i,
  input  wire logic              por_i,
  input  wire logic              brownout_i,
  input  wire logic              porta_pin5_i,
  input  wire logic              osc_in_i,
  // core events
  input  wire logic              sleep_req_i,
  input  wire logic              wdt_wake_i,
  input  wire logic              irq_i,
  // decoded settings and reset state
  output cwd_cfg_t               cfg_o,
  output logic                   master_clear_n_o,
  output logic                   device_reset_o,
  output logic                   sleeping_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic prog_s;
  logic por_s;
  logic bor_s;
  logic pin5_s;
  logic osc_s;

  cwd_sync #(.RESET_VAL(1'b0)) u_sync_prog (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pin_i     (prog_mode_i),
    .level_o   (prog_s)
  );

  cwd_sync #(.RESET_VAL(1'b0)) u_sync_por (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pin_i     (por_i),
    .level_o   (por_s)
  );

  cwd_sync #(.RESET_VAL(1'b0)) u_sync_bor (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pin_i     (brownout_i),
    .level_o   (bor_s)
  );

  cwd_sync #(.RESET_VAL(1'b1)) u_sync_pin5 (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pin_i     (porta_pin5_i),
    .level_o   (pin5_s)
  );

  cwd_sync #(.RESET_VAL(1'b0)) u_sync_osc (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pin_i     (osc_in_i),
    .level_o   (osc_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // configuration word store

  logic [CFG_W-1:0] cfg_word;
  logic             osc_prev;

  wire hit_cfg  = (addr_i == CFG_ADDR);
  wire hit_stat = (addr_i == STAT_ADDR);
  wire cfg_wr   = wr_en_i && hit_cfg && prog_s; // R02

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cfg_word <= CFG_ERASED; // R03
    end else if (cfg_wr) begin
      cfg_word <= wr_data_i[CFG_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field decode, 0 means programmed

  cwd_cfg_t next_cfg;
  logic     [1:0] wrt;
  cwd_osc_t osc;

  assign wrt = cfg_word[BIT_WRT_HI:BIT_WRT_LO];
  assign osc = cwd_osc_t'({cfg_word[BIT_FOSC2], cfg_word[BIT_FOSC1], cfg_word[BIT_FOSC0]}); // R01

  assign next_cfg.code_protect   = !cfg_word[BIT_CP]; // R04
  assign next_cfg.ccp_on_pin2    = cfg_word[BIT_COMPARE_PIN_SELECT]; // R05
  assign next_cfg.debug_pins     = !cfg_word[BIT_DBG]; // R06
  assign next_cfg.eeprom_protect = !cfg_word[BIT_CPD]; // R09
  assign next_cfg.lvp_pin        = cfg_word[BIT_LVP]; // R10
  assign next_cfg.brownout_en    = cfg_word[BIT_BOR]; // R11
  assign next_cfg.master_clear_n_pin       = cfg_word[BIT_RESET_PIN_SELECT]; // R12
  assign next_cfg.powerup_delay_timer_en        = !cfg_word[BIT_POWERUP_DELAY_ENABLE_N]; // R13
  assign next_cfg.wdt_en         = cfg_word[BIT_WATCHDOG_ENABLE]; // R14
  assign next_cfg.osc_mode       = osc; // R16
  assign next_cfg.clkout_on_pin6 = (osc == OSC_EXT_CLOCK_OUT_FUNCTION) || (osc == OSC_INT_CLOCK_OUT_FUNCTION); // R15
  assign next_cfg.pin6_io        = (osc == OSC_EXT_IO) || (osc == OSC_INT_IO) || (osc == OSC_EXT_CLK); // R15
  assign next_cfg.pin7_io        = (osc == OSC_INT_CLOCK_OUT_FUNCTION) || (osc == OSC_INT_IO); // R15
  assign next_cfg.wp_en          = (wrt != WRT_OFF); // R07
  assign next_cfg.wp_top         = (wrt == WRT_LOW) ? WP_TOP_LOW :
                                   (wrt == WRT_MID) ? WP_TOP_MID :
                                   (wrt == WRT_OFF) ? 12'h000 :
                                   LARGE_MEM        ? WP_TOP_HIGH : WP_TOP_MID; // R08

  wire crystal_live = (osc == OSC_LP_XTAL) || (osc == OSC_STD_XTAL) || (osc == OSC_HS_XTAL); // R21
  wire crystal_held = (cfg_o.osc_mode == OSC_LP_XTAL) || (cfg_o.osc_mode == OSC_STD_XTAL) ||
                      (cfg_o.osc_mode == OSC_HS_XTAL);

  ////////////////////////////////////////////////////////////////////////////
  // power-up and start-up timers

  logic powerup_delay_timer_done;
  logic ost_done;
  cwd_state_t state;
  cwd_state_t next_state;

  wire osc_rise = osc_s && !osc_prev;

  cwd_delay_cnt #(.LIMIT(POWERUP_DELAY_TIMER_LIMIT)) u_powerup_delay_timer (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .clear_i   (state != ST_POWERUP_DELAY_TIMER),
    .tick_i    (1'b1),
    .done_o    (powerup_delay_timer_done)
  ); // R17

  cwd_delay_cnt #(.LIMIT(OST_CYCLES)) u_ost (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .clear_i   (state != ST_OST),
    .tick_i    (osc_rise),
    .done_o    (ost_done)
  ); // R18

  ////////////////////////////////////////////////////////////////////////////
  // reset sequencer

  wire master_clear_n_int_n = cfg_o.master_clear_n_pin ? pin5_s : 1'b1; // R12
  wire power_rst  = por_s || (bor_s && cfg_o.brownout_en); // R11
  wire held_state = (state == ST_LOAD) || (state == ST_HOLD);

  always_comb begin
    next_state = state;
    case (state)
      ST_LOAD: begin
        if (!power_rst) begin
          if (next_cfg.powerup_delay_timer_en) next_state = ST_POWERUP_DELAY_TIMER; // R17
          else if (crystal_live) next_state = ST_OST; // R21
          else next_state = master_clear_n_int_n ? ST_RUN : ST_HOLD;
        end
      end
      ST_POWERUP_DELAY_TIMER: begin
        if (powerup_delay_timer_done) begin
          if (crystal_held) next_state = ST_OST; // R21
          else next_state = master_clear_n_int_n ? ST_RUN : ST_HOLD;
        end
      end
      ST_OST: begin
        if (ost_done) next_state = master_clear_n_int_n ? ST_RUN : ST_HOLD; // R18
      end
      ST_HOLD: begin
        if (master_clear_n_int_n) next_state = ST_RUN;
      end
      ST_RUN: begin
        if (!master_clear_n_int_n) next_state = ST_HOLD;
        else if (sleep_req_i) next_state = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (!master_clear_n_int_n) next_state = ST_HOLD; // R19
        else if (wdt_wake_i || irq_i) next_state = crystal_held ? ST_OST : ST_RUN; // R19
      end
      default: next_state = ST_LOAD;
    endcase
    if (power_rst) next_state = ST_LOAD;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state            <= ST_LOAD;
      osc_prev         <= 1'b0;
      cfg_o            <= '0;
      master_clear_n_o <= 1'b1;
      device_reset_o   <= 1'b1;
      sleeping_o       <= 1'b0;
    end else begin
      state            <= next_state;
      osc_prev         <= osc_s;
      if (held_state) cfg_o <= next_cfg; // R22
      master_clear_n_o <= master_clear_n_int_n; // R12
      device_reset_o   <= (next_state != ST_RUN) && (next_state != ST_SLEEP);
      sleeping_o       <= (next_state == ST_SLEEP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port

  logic [DATA_W-1:0] next_rd;

  wire [DATA_W-1:0] cfg_read  = {UNIMPL_BITS, cfg_word}; // R20
  wire [DATA_W-1:0] stat_read = {12'h000, prog_s, sleeping_o, device_reset_o, master_clear_n_o};

  assign next_rd = !rd_en_i           ? '0 :
                   (hit_cfg && prog_s) ? cfg_read : // R02
                   hit_stat           ? stat_read : '0;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= next_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  property p_erased;
    rst_i |=> (cfg_word == CFG_ERASED);
  endproperty
  a_erased: assert property (disable iff (1'b0) p_erased) else $error("word not erased after reset"); // R03

  property p_locked_write;
    (wr_en_i && hit_cfg && !prog_s) |=> $stable(cfg_word);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("word changed outside programming"); // R02

  property p_locked_read;
    (rd_en_i && hit_cfg && !prog_s) |=> (rd_data_o == '0);
  endproperty
  a_locked_read: assert property (p_locked_read) else $error("word visible outside programming"); // R02

  property p_unimpl_ones;
    (rd_en_i && hit_cfg && prog_s) |=> (rd_data_o[DATA_W-1:CFG_W] == UNIMPL_BITS);
  endproperty
  a_unimpl_ones: assert property (p_unimpl_ones) else $error("unused word bits not read as one"); // R20

  property p_static_run;
    (state == ST_RUN) ##1 (state == ST_RUN) |-> $stable(cfg_o);
  endproperty
  a_static_run: assert property (p_static_run) else $error("settings moved while running"); // R22

  property p_code_prot;
    (state == ST_LOAD) |=> (cfg_o.code_protect == !$past(cfg_word[BIT_CP]));
  endproperty
  a_code_prot: assert property (p_code_prot) else $error("code protect decoded wrongly"); // R04

  property p_powerup_delay_timer_only_en;
    (state == ST_POWERUP_DELAY_TIMER) |-> cfg_o.powerup_delay_timer_en && $past(state) inside {ST_LOAD, ST_POWERUP_DELAY_TIMER};
  endproperty
  a_powerup_delay_timer_only_en: assert property (p_powerup_delay_timer_only_en) else $error("power-up delay entered wrongly"); // R17

  property p_ost_crystal;
    (state == ST_OST) |-> crystal_held;
  endproperty
  a_ost_crystal: assert property (p_ost_crystal) else $error("start-up timer in non-crystal mode"); // R21

  property p_tied_high;
    (!cfg_o.master_clear_n_pin && !$past(cfg_o.master_clear_n_pin)) |-> master_clear_n_o;
  endproperty
  a_tied_high: assert property (p_tied_high) else $error("master clear not tied inactive"); // R12

  property p_wake;
    (state == ST_SLEEP && (irq_i || wdt_wake_i) && !power_rst) |=> (state != ST_SLEEP) ##1 !sleeping_o;
  endproperty
  a_wake: assert property (p_wake) else $error("sleep not left on wake event"); // R19

  property p_ccp_pin;
    (state == ST_LOAD) |=> (cfg_o.ccp_on_pin2 == $past(cfg_word[BIT_COMPARE_PIN_SELECT]));
  endproperty
  a_ccp_pin: assert property (p_ccp_pin) else $error("capture pin choice decoded wrongly"); // R05

  property p_debug_pins;
    (state == ST_LOAD) |=> (cfg_o.debug_pins == !$past(cfg_word[BIT_DBG]));
  endproperty
  a_debug_pins: assert property (p_debug_pins) else $error("debugger pins decoded wrongly"); // R06

  property p_wp_en;
    (state == ST_LOAD) |=> (cfg_o.wp_en == ($past(cfg_word[BIT_WRT_HI:BIT_WRT_LO]) != WRT_OFF));
  endproperty
  a_wp_en: assert property (p_wp_en) else $error("write guard enable decoded wrongly"); // R07

  property p_clkout_pin6;
    cfg_o.clkout_on_pin6 |-> !cfg_o.pin6_io;
  endproperty
  a_clkout_pin6: assert property (p_clkout_pin6) else $error("pin 6 both clock out and port"); // R15

  property p_hold_reset;
    (state == ST_HOLD) |-> device_reset_o;
  endproperty
  a_hold_reset: assert property (p_hold_reset) else $error("device released while master clear held"); // R12

  c_powerup_delay_timer_path:  cover property ((state == ST_POWERUP_DELAY_TIMER) ##1 (state == ST_OST));
  c_sleep_wake: cover property ((state == ST_SLEEP) ##1 (state == ST_RUN));
  c_prog_write: cover property (cfg_wr ##1 (rd_en_i && hit_cfg && prog_s));
  c_hold_run:   cover property ((state == ST_HOLD) ##1 (state == ST_RUN));

endmodule : cwd_config_decoder

/* cwd_config_decoder_bench.sv */
// self-checking testbench of the configuration word decoder
`timescale 1ns/10ps
module cwd_config_decoder_bench
  import cwd_pkg::*;
;
  localparam int DELAY_LIM = 20;
  logic              sys_clk_i, rst_i, por_i, brownout_i, porta_pin5_i;
  logic              osc_in_i, sleep_req_i, wdt_wake_i, irq_i;
  logic              prog_mode, wr_en, rd_en, master_clear_n_n, dev_rst, sleeping;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data, rd_data;
  cwd_cfg_t          cfg, cur_cfg;
  int                bad_count, comparisons, osc_div;

  cwd_config_decoder #(.LARGE_MEM(1'b1), .POWERUP_DELAY_TIMER_LIMIT(DELAY_LIM)) cwd_config_decoder_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr), .wr_data_i(wr_data),
    .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rd_data), .prog_mode_i(prog_mode),
    .por_i(por_i), .brownout_i(brownout_i), .porta_pin5_i(porta_pin5_i), .osc_in_i(osc_in_i),
    .sleep_req_i(sleep_req_i), .wdt_wake_i(wdt_wake_i), .irq_i(irq_i), .cfg_o(cfg),
    .master_clear_n_o(master_clear_n_n), .device_reset_o(dev_rst), .sleeping_o(sleeping));
  cwd_prog_model cwd_prog_model_i (
    .sys_clk_i(sys_clk_i), .rd_data_i(rd_data), .addr_o(addr), .wr_data_o(wr_data),
    .wr_en_o(wr_en), .rd_en_o(rd_en), .prog_mode_o(prog_mode));
  ////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  // oscillator input, four clocks high and four low
  always @(posedge sys_clk_i) begin
    osc_div <= osc_div + 1;
    if (osc_div % 4 == 3) osc_in_i <= ~osc_in_i;
  end
  ////////////////////////////////////////////////////////////////
  function automatic cwd_cfg_t exp_cfg(input logic [13:0] w);
    cwd_cfg_t   c;
    logic [2:0] m;
    m = {w[4], w[1:0]};
    c.code_protect   = ~w[13];
    c.eeprom_protect = ~w[8];
    c.ccp_on_pin2    = w[12];
    c.debug_pins     = ~w[11];
    c.lvp_pin        = w[7];
    c.brownout_en    = w[6];
    c.master_clear_n_pin       = w[5];
    c.powerup_delay_timer_en        = ~w[3];
    c.wdt_en         = w[2];
    c.osc_mode       = cwd_osc_t'(m);
    c.clkout_on_pin6 = (m == 3'h7) || (m == 3'h5);
    c.pin6_io        = (m == 3'h6) || (m == 3'h4) || (m == 3'h3);
    c.pin7_io        = (m == 3'h5) || (m == 3'h4);
    c.wp_en          = (w[10:9] != 2'h3);
    case (w[10:9])
      2'h2: c.wp_top = 12'h1ff;
      2'h1: c.wp_top = 12'h3ff;
      2'h0: c.wp_top = 12'h5ff;
      default: c.wp_top = 12'h000;
    endcase
    return c;
  endfunction : exp_cfg

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  task automatic chk16(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk16

  task automatic chk_cfg(input string n, input cwd_cfg_t e, input cwd_cfg_t g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk_cfg

  task automatic chk_rng(input string n, input int lo, input int hi, input int g);
    comparisons++;
    if (g < lo || g > hi) begin
      bad_count++;
      $display("ERROR %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask : chk_rng

  // wait for the reset output to reach v, counting clocks and oscillator rises
  task automatic wait_rst(input logic v, output int n, output int e);
    logic p;
    n = 0;
    e = 0;
    p = osc_in_i;
    while (dev_rst !== v) begin
      @(posedge sys_clk_i);
      n++;
      if (osc_in_i && !p) e++;
      p = osc_in_i;
      if (n > 20000) begin
        bad_count++;
        $display("ERROR reset level expected %b seen timeout", v);
        test_done();
      end
    end
  endtask : wait_rst

  // program a word, read it back, then power-on reset to take it
  task automatic apply(input logic [13:0] w, output int n, output int e);
    logic [DATA_W-1:0] d;
    cwd_prog_model_i.set_prog(1'b1);
    cwd_prog_model_i.wr(CFG_ADDR, {2'b00, w});
    cwd_prog_model_i.rd(CFG_ADDR, d);
    chk16("word readback", {2'b11, w}, d);
    cwd_prog_model_i.set_prog(1'b0);
    chk_cfg("settings while running", cur_cfg, cfg);
    @(posedge sys_clk_i);
    por_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    por_i <= 1'b0;
    wait_rst(1'b0, n, e);
    cur_cfg = exp_cfg(w);
    chk_cfg("decoded settings", cur_cfg, cfg);
  endtask : apply
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [DATA_W-1:0] d;
    repeat (3) @(posedge sys_clk_i);
    cur_cfg = exp_cfg(CFG_ERASED);
    chk_cfg("erased settings", cur_cfg, cfg);
    cwd_prog_model_i.wr(CFG_ADDR, 16'h0000);
    cwd_prog_model_i.rd(CFG_ADDR, d);
    chk16("word outside programming", 16'h0000, d);
    cwd_prog_model_i.set_prog(1'b1);
    cwd_prog_model_i.rd(CFG_ADDR, d);
    chk16("erased word", 16'hffff, d);
    cwd_prog_model_i.rd(STAT_ADDR, d);
    chk16("status word", 16'h0009, d);
    cwd_prog_model_i.rd(14'h0000, d);
    chk16("unmapped word", 16'h0000, d);
    cwd_prog_model_i.set_prog(1'b0);
  endtask : t_reset

  task automatic t_fields;
    logic [13:0] b [4] = '{14'h3fff, 14'h2aa8, 14'h156c, 14'h0928};
    logic [13:0] w;
    int          n, e;
    for (int i = 0; i < 8; i++) begin
      w = b[i % 4];
      w[4] = i[2];
      w[1:0] = i[1:0];
      apply(w, n, e);
      if (i < 3) chk_rng("start-up oscillator edges", 1024, 1028, e);
      else chk_rng("rc start cycles", 0, 8, n);
    end
  endtask : t_fields

  task automatic t_delay;
    int n, e;
    apply(14'h3ff7, n, e);
    chk_rng("power-up delay cycles", DELAY_LIM, DELAY_LIM + 8, n);
    @(posedge sys_clk_i);
    porta_pin5_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    chk16("master clear out", 16'h0, 16'(master_clear_n_n));
    chk16("held by master clear", 16'h1, 16'(dev_rst));
    porta_pin5_i <= 1'b1;
    wait_rst(1'b0, n, e);
    chk_rng("master clear release cycles", 0, 8, n);
  endtask : t_delay

  task automatic t_pins;
    int n, e;
    apply(14'h3f9f, n, e);
    @(posedge sys_clk_i);
    porta_pin5_i <= 1'b0;
    brownout_i   <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    chk16("master clear tied", 16'h1, 16'(master_clear_n_n));
    chk16("reset with pin and brown-out off", 16'h0, 16'(dev_rst));
    porta_pin5_i <= 1'b1;
    brownout_i   <= 1'b0;
    apply(14'h3fff, n, e);
    brownout_i <= 1'b1;
    wait_rst(1'b1, n, e);
    chk_rng("brown-out reset cycles", 0, 8, n);
    brownout_i <= 1'b0;
    wait_rst(1'b0, n, e);
  endtask : t_pins

  task automatic t_sleep;
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk_i);
      sleep_req_i <= 1'b1;
      @(posedge sys_clk_i);
      sleep_req_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      chk16("sleeping", 16'h1, 16'(sleeping));
      irq_i        <= (i == 0);
      wdt_wake_i   <= (i == 1);
      porta_pin5_i <= (i != 2);
      repeat (4) @(posedge sys_clk_i);
      irq_i        <= 1'b0;
      wdt_wake_i   <= 1'b0;
      porta_pin5_i <= 1'b1;
      repeat (8) @(posedge sys_clk_i);
      chk16("awake", 16'h0, 16'(sleeping));
      chk16("running after wake", 16'h0, 16'(dev_rst));
    end
  endtask : t_sleep
  ////////////////////////////////////////////////////////////////
  initial begin
    rst_i        = 1'b1;
    por_i        = 1'b0;
    brownout_i   = 1'b0;
    porta_pin5_i = 1'b1;
    osc_in_i     = 1'b0;
    sleep_req_i  = 1'b0;
    wdt_wake_i   = 1'b0;
    irq_i        = 1'b0;
    osc_div      = 0;
    bad_count    = 0;
    comparisons  = 0;
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_fields();
    t_delay();
    t_pins();
    t_sleep();
    test_done();
  end
endmodule : cwd_config_decoder_bench

/* cwd_delay_cnt.sv */
// tick counter that raises done once a limit of ticks has been seen
`timescale 1ns/10ps
module cwd_delay_cnt
  import cwd_pkg::*;
#(
  parameter int LIMIT = OST_CYCLES,
  parameter int CW    = $clog2(LIMIT + 1)
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  // control
  input  wire logic clear_i,
  input  wire logic tick_i,
  output logic      done_o
);

  localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

  logic [CW-1:0] count;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || clear_i) begin
      count  <= '0;
      done_o <= 1'b0;
    end else if (tick_i && !done_o) begin
      count  <= count + CW'(1);
      done_o <= (count == LAST);
    end
  end

endmodule : cwd_delay_cnt

/* cwd_pkg.sv */
// shared constants, types and field layout of the configuration word decoder
package cwd_pkg;

  localparam int          DATA_W      = 16;
  localparam int          ADDR_W      = 14;
  localparam int          CFG_W       = 14;
  localparam logic [13:0] CFG_ADDR    = 14'h2007;
  localparam logic [13:0] STAT_ADDR   = 14'h2008;
  localparam logic [13:0] CFG_ERASED  = 14'h3fff;
  localparam logic [1:0]  UNIMPL_BITS = 2'h3;

  localparam int BIT_CP     = 13;
  localparam int BIT_COMPARE_PIN_SELECT  = 12;
  localparam int BIT_DBG    = 11;
  localparam int BIT_WRT_HI = 10;
  localparam int BIT_WRT_LO = 9;
  localparam int BIT_CPD    = 8;
  localparam int BIT_LVP    = 7;
  localparam int BIT_BOR    = 6;
  localparam int BIT_RESET_PIN_SELECT  = 5;
  localparam int BIT_FOSC2  = 4;
  localparam int BIT_POWERUP_DELAY_ENABLE_N = 3;
  localparam int BIT_WATCHDOG_ENABLE  = 2;
  localparam int BIT_FOSC1  = 1;
  localparam int BIT_FOSC0  = 0;

  localparam logic [1:0]  WRT_OFF     = 2'h3;
  localparam logic [1:0]  WRT_LOW     = 2'h2;
  localparam logic [1:0]  WRT_MID     = 2'h1;
  localparam logic [11:0] WP_TOP_LOW  = 12'h1ff;
  localparam logic [11:0] WP_TOP_MID  = 12'h3ff;
  localparam logic [11:0] WP_TOP_HIGH = 12'h5ff;

  localparam int POWERUP_DELAY_TIMER_MS      = 72;
  localparam int CLK_KHZ      = 250000;
  localparam int POWERUP_DELAY_TIMER_CYCLES  = POWERUP_DELAY_TIMER_MS * CLK_KHZ;
  localparam int OST_CYCLES   = 1024;
  localparam int SYNC_STAGES  = 2;

  typedef enum logic [2:0] {
    OSC_LP_XTAL  = 3'h0,
    OSC_STD_XTAL = 3'h1,
    OSC_HS_XTAL  = 3'h2,
    OSC_EXT_CLK  = 3'h3,
    OSC_INT_IO   = 3'h4,
    OSC_INT_CLOCK_OUT_FUNCTION = 3'h5,
    OSC_EXT_IO   = 3'h6,
    OSC_EXT_CLOCK_OUT_FUNCTION = 3'h7
  } cwd_osc_t;

  typedef enum {
    ST_LOAD,
    ST_POWERUP_DELAY_TIMER,
    ST_OST,
    ST_HOLD,
    ST_RUN,
    ST_SLEEP
  } cwd_state_t;

  typedef struct packed {
    logic        code_protect;
    logic        eeprom_protect;
    logic        ccp_on_pin2;
    logic        debug_pins;
    logic        lvp_pin;
    logic        brownout_en;
    logic        master_clear_n_pin;
    logic        powerup_delay_timer_en;
    logic        wdt_en;
    cwd_osc_t    osc_mode;
    logic        clkout_on_pin6;
    logic        pin6_io;
    logic        pin7_io;
    logic        wp_en;
    logic [11:0] wp_top;
  } cwd_cfg_t;

endpackage : cwd_pkg

/* cwd_prog_model.sv */
// programmer model: programming mode pin and register port master
`timescale 1ns/10ps
module cwd_prog_model
  import cwd_pkg::*;
(
  // clock
  input  wire logic              sys_clk_i,
  // register port
  input  wire logic [DATA_W-1:0] rd_data_i,
  output logic      [ADDR_W-1:0] addr_o,
  output logic      [DATA_W-1:0] wr_data_o,
  output logic                   wr_en_o,
  output logic                   rd_en_o,
  // programming mode
  output logic                   prog_mode_o
);
  initial begin
    addr_o      = '0;
    wr_data_o   = '0;
    wr_en_o     = 1'b0;
    rd_en_o     = 1'b0;
    prog_mode_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // mode change, then wait out the pin synchroniser
  task automatic set_prog(input logic on);
    @(posedge sys_clk_i);
    prog_mode_o <= on;
    repeat (3) @(posedge sys_clk_i);
  endtask : set_prog
  // one-cycle write; data lines scrambled once released
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk_i);
    addr_o    <= a;
    wr_data_o <= d;
    wr_en_o   <= 1'b1;
    @(posedge sys_clk_i);
    wr_en_o   <= 1'b0;
    wr_data_o <= ~d;
  endtask : wr
  // one-cycle read; data stands the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge sys_clk_i);
    addr_o  <= a;
    rd_en_o <= 1'b1;
    @(posedge sys_clk_i);
    rd_en_o <= 1'b0;
    addr_o  <= ~a;
    #1;
    d = rd_data_i;
  endtask : rd
endmodule : cwd_prog_model

/* cwd_sync.sv */
// two-stage synchroniser for one asynchronous pin
`timescale 1ns/10ps
module cwd_sync
  import cwd_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  // pin and synchronised level
  input  wire logic pin_i,
  output logic      level_o
);

  logic stage1;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stage1  <= RESET_VAL;
      level_o <= RESET_VAL;
    end else begin
      stage1  <= pin_i;
      level_o <= stage1;
    end
  end

endmodule : cwd_sync
